// >>> src/ppac_port.sv
`timescale 1ns/100ps
module ppac_port (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic parallel_async_host_mode,
	input wire logic remote_config_mode,
	input wire logic config_start,
	input wire logic config_done,
	input wire logic init_done,
	input wire logic select_active_low,
	input wire logic select_active_high,
	input wire logic read_status_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [ppac_pkg::PPAC_DATA_W-1:0] data_in,
	input wire logic update_source_select,
	input wire logic [ppac_pkg::PPAC_PAGE_W-1:0] page_request,
	input wire logic page_load,
	output logic status_data_bit,
	output logic status_data_bit_oe,
	output logic ready_not_busy,
	output logic ready_not_busy_oe,
	output logic [ppac_pkg::PPAC_DATA_W-1:0] byte_data,
	output logic byte_valid,
	output logic remote_update,
	output logic [ppac_pkg::PPAC_PAGE_W-1:0] page_select,
	output logic page_select_oe,
	output logic user_io_release,
	output logic [1:0] cfg_phase
);
	import ppac_pkg::*;

	localparam int NSYNC = 6 + PPAC_DATA_W;

	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] syn;
	ppac_state_t state;
	ppac_state_t next_state;
	logic ws_prev;
	logic [PPAC_CNT_W-1:0] busy_cnt;
	logic [PPAC_CNT_W-1:0] next_busy_cnt;

	// Mode, select, strobe, update-source and data pins pass two flops; data is resampled with the strobe so both line up
	// Strobes enter inverted, so the cleared synchroniser reads as idle high (no false edge)
	assign raw_in = {data_in, update_source_select, ~write_strobe_n, ~read_status_strobe_n,
		select_active_high, select_active_low, parallel_async_host_mode};
	ppac_sync #(.W(NSYNC)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.din(raw_in),
		.dout(syn)
	);

	wire mode_s = syn[0];
	wire sel_n_s = syn[1];
	wire sel_s = syn[2];
	wire rs_n_s = !syn[3];
	wire ws_n_s = !syn[4];
	wire upd_s = syn[5];
	wire [PPAC_DATA_W-1:0] data_s = syn[NSYNC-1:6];

	// Decode of selection, strobe edge and phase
	wire selected = !sel_n_s && sel_s;
	wire ws_rise = ws_n_s && !ws_prev;
	wire in_load = (state == PPAC_LOAD);
	wire accept = in_load && mode_s && selected && ws_rise && (busy_cnt == '0);
	wire active_cfg = (state != PPAC_USER);
	wire ppa_pins = mode_s && active_cfg;
	wire next_rdy = (busy_cnt == '0) && !accept;
	wire next_remote = remote_config_mode && upd_s;

	// Phase sequencing of the configuration flow
	always_comb begin
		next_state = state;
		case (state)
			PPAC_IDLE: if (config_start) next_state = PPAC_LOAD;
			PPAC_LOAD: if (config_done) next_state = PPAC_INIT;
			PPAC_INIT: if (init_done) next_state = PPAC_USER;
			PPAC_USER: next_state = PPAC_USER;
			default: next_state = PPAC_IDLE;
		endcase
	end

	// Busy window restarts on each accepted byte
	always_comb begin
		next_busy_cnt = busy_cnt;
		if (accept) begin
			next_busy_cnt = PPAC_BUSY_LOAD;
		end else if (busy_cnt != '0) begin
			next_busy_cnt = busy_cnt - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= PPAC_IDLE;
			busy_cnt <= '0;
			ws_prev <= 1'b1;
		end else begin
			state <= next_state;
			busy_cnt <= next_busy_cnt;
			ws_prev <= ws_n_s;
		end
	end

	// Byte capture; outputs kept registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			byte_data <= '0;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= accept;
			if (accept) begin
				byte_data <= data_s;
			end
		end
	end

	// Pin drivers; tri-state whenever the pins are not in the host role
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ready_not_busy <= 1'b1;
			ready_not_busy_oe <= 1'b0;
			status_data_bit <= 1'b1;
			status_data_bit_oe <= 1'b0;
			user_io_release <= 1'b0;
			cfg_phase <= 2'h0;
		end else begin
			ready_not_busy <= next_rdy;
			ready_not_busy_oe <= ppa_pins;
			status_data_bit <= next_rdy;
			status_data_bit_oe <= ppa_pins && !rs_n_s;
			user_io_release <= !active_cfg;
			cfg_phase <= state;
		end
	end

	// Remote update source and page output; released as GPIO without remote mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			remote_update <= 1'b0;
			page_select <= PPAC_PAGE_RST;
			page_select_oe <= 1'b0;
		end else begin
			remote_update <= next_remote;
			page_select_oe <= remote_config_mode;
			if (remote_config_mode && page_load) begin
				page_select <= page_request;
			end
		end
	end

	// Outside host mode the status pins must never be driven
	AST_TRISTATE_NON_PPA: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(mode_s) |-> (!ready_not_busy_oe && !status_data_bit_oe))
		else $error("status pins driven outside host mode");
	// A taken byte drops ready for the whole busy window
	AST_BUSY_AFTER_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
		accept |=> !ready_not_busy [*8])
		else $error("ready rose before busy window ended");
	// Ready returns within 10 cycles of a taken byte
	AST_READY_RETURNS: assert property (@(posedge clock) disable iff (!rst_n)
		accept |-> ##[1:10] ready_not_busy)
		else $error("ready did not return");
	// Status bit mirrors ready while driven
	AST_STATUS_MIRROR: assert property (@(posedge clock) disable iff (!rst_n)
		status_data_bit_oe |-> status_data_bit == ready_not_busy)
		else $error("status bit differs from ready");
	// Read strobe low in host config drives bit 7 next cycle
	AST_READ_DRIVES: assert property (@(posedge clock) disable iff (!rst_n)
		(ppa_pins && !rs_n_s) |=> status_data_bit_oe)
		else $error("status bit not driven on read strobe");
	// No byte without selection
	AST_SELECT_GATES: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> $past(selected))
		else $error("byte taken while not selected");
	// Captured byte matches the bus at the strobe edge
	AST_BYTE_VALUE: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> byte_data == $past(data_s))
		else $error("captured byte wrong");
	// Pins released once in user mode
	AST_USER_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
		$past(state) == PPAC_USER |-> (user_io_release && !ready_not_busy_oe))
		else $error("pins not released in user mode");
	// Remote flag follows the update source
	AST_REMOTE_SEL: assert property (@(posedge clock) disable iff (!rst_n)
		remote_update == $past(next_remote))
		else $error("update source decode wrong");
	// Page output idle as GPIO without remote mode
	AST_PAGE_GPIO: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(remote_config_mode) |-> !page_select_oe)
		else $error("page select driven without remote mode");
	// Idle loader in host mode shows ready, driven, in every phase before user mode
	AST_READY_BEFORE_USER: assert property (@(posedge clock) disable iff (!rst_n)
		($past(ppa_pins) && $past(busy_cnt) == '0 && !$past(accept)) |-> (ready_not_busy && ready_not_busy_oe))
		else $error("ready not driven high while idle in configuration");
	// Bytes are only taken while loading
	AST_BYTE_IN_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> $past(state) == PPAC_LOAD)
		else $error("byte taken outside the load phase");
	// No byte is taken while the busy window runs
	AST_BYTE_NOT_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> $past(busy_cnt) == '0)
		else $error("byte taken while busy");
	// One strobe edge gives at most one byte
	AST_VALID_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |=> !byte_valid)
		else $error("byte valid longer than one cycle");
	// A byte needs a rising write strobe
	AST_BYTE_NEEDS_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> ($past(ws_n_s) && !$past(ws_prev)))
		else $error("byte taken without a strobe edge");
	// Outside host mode the strobe is user I/O and loads nothing
	AST_BYTE_HOST_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
		byte_valid |-> $past(mode_s))
		else $error("byte taken outside host mode");
	// Read strobe high leaves data bit 7 undriven
	AST_STATUS_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rs_n_s) |-> !status_data_bit_oe)
		else $error("status bit driven without read strobe");
	// Page output only moves on a load request
	AST_PAGE_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(page_load) |-> $stable(page_select))
		else $error("page select changed without load");
	// Pins are handed to user I/O only in user mode
	AST_RELEASE_ONLY_USER: assert property (@(posedge clock) disable iff (!rst_n)
		user_io_release |-> $past(state) == PPAC_USER)
		else $error("pins released before user mode");
endmodule // ppac_port

// >>> common/ppac_pkg.sv
// Functional notes
// - While the read-status strobe is low in parallel host mode, ready/busy is driven on data bit 7.
// - Ready/busy is high when another byte can be taken and low while the device is busy.
// - Ready/busy is high after power-up before configuration and after configuration until user mode.
// - The device is selected only with the active-low select low and the active-high select high.
// - Outside parallel host mode the strobe, ready/busy and select pins stay tri-stated.
// - After parallel configuration those pins become user I/O set by the shared-pin setting.
// - In remote configuration, update-source high selects remote update and low selects local.
// - In remote configuration, a three-bit page select picks one of eight memory pages.
// - Without remote or local update, update-source and page select are general-purpose I/O.
// - Optional pins that are not enabled stay tri-stated with weak pull-ups during configuration.
// - One data byte is captured on each rising edge of the active-low write strobe.
package ppac_pkg;
	localparam int PPAC_DATA_W = 8;
	localparam int PPAC_PAGE_W = 3;
	localparam int PPAC_STATUS_BIT = 7;
	// Time the loader needs per byte before it is ready again
	localparam int PPAC_BUSY_NS = 40;
	localparam int PPAC_CLK_NS = 5;
	localparam int PPAC_BUSY_CYC = (PPAC_BUSY_NS + PPAC_CLK_NS - 1) / PPAC_CLK_NS;
	localparam int PPAC_CNT_W = 4;
	localparam logic [PPAC_CNT_W-1:0] PPAC_BUSY_LOAD = PPAC_CNT_W'(PPAC_BUSY_CYC);
	localparam logic [PPAC_PAGE_W-1:0] PPAC_PAGE_RST = 3'h0;
	typedef enum logic [1:0] {
		PPAC_IDLE = 2'b00,
		PPAC_LOAD = 2'b01,
		PPAC_INIT = 2'b10,
		PPAC_USER = 2'b11
	} ppac_state_t;
endpackage

// >>> src/ppac_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser, one instance for the whole W-bit bus
module ppac_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;
	// First stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // ppac_sync

// >>> testbench/ppac_host.sv
`timescale 1ns/100ps
// Host model: drives the strobes and the byte bus
module ppac_host (
	input wire logic clock,
	output logic write_strobe_n,
	output logic read_status_strobe_n,
	output logic [7:0] data_in
);
	// Idle levels; read strobe parked high until rs drives it
	initial begin
		write_strobe_n = 1'b1;
		read_status_strobe_n = 1'b1;
		data_in = 8'h00;
	end
	// Byte is held past the sync delay, then the bus goes stale
	task automatic put(input logic [7:0] b);
		@(negedge clock);
		data_in = b;
		write_strobe_n = 1'b0;
		repeat (3) @(negedge clock);
		write_strobe_n = 1'b1;
		repeat (3) @(negedge clock);
		data_in = ~b;
	endtask
	task automatic rs(input logic lvl);
		read_status_strobe_n = lvl;
	endtask
endmodule // ppac_host

// >>> testbench/test_ppac_port.sv
`timescale 1ns/100ps
module test_ppac_port;
	import ppac_pkg::*;
	logic clock = 0, rst_n = 0, mode = 1, rmode = 0, start = 0, cdone = 0;
	logic idone = 0, sel_n = 0, sel = 1, upd = 0, pload = 0;
	logic [2:0] preq = 3'h0;
	logic wsn, rsn, sdb, sdb_oe, rdy, rdy_oe, bval, rupd, pg_oe, rel;
	logic [7:0] din, bdata;
	logic [2:0] pg;
	logic [1:0] ph;
	int errors = 0, tests_run = 0;
	ppac_host host (.clock(clock), .write_strobe_n(wsn), .read_status_strobe_n(rsn),
		.data_in(din));
	ppac_port dut (.clock(clock), .rst_n(rst_n), .parallel_async_host_mode(mode),
		.remote_config_mode(rmode), .config_start(start), .config_done(cdone),
		.init_done(idone), .select_active_low(sel_n), .select_active_high(sel),
		.read_status_strobe_n(rsn), .write_strobe_n(wsn), .data_in(din),
		.update_source_select(upd), .page_request(preq), .page_load(pload),
		.status_data_bit(sdb), .status_data_bit_oe(sdb_oe), .ready_not_busy(rdy),
		.ready_not_busy_oe(rdy_oe), .byte_data(bdata), .byte_valid(bval),
		.remote_update(rupd), .page_select(pg), .page_select_oe(pg_oe),
		.user_io_release(rel), .cfg_phase(ph));
	task automatic tally_and_finish();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_n(int k);
		repeat (k) @(negedge clock);
	endtask
	// Waits for ready, then writes; a refused byte must give no pulse
	task automatic send(input logic [7:0] b, input logic acc);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		chk({7'h0, rdy}, 8'h01);
		if (rdy !== 1'b1) tally_and_finish();
		fork
			host.put(b);
			begin
				n = 0;
				while (bval !== 1'b1 && n < 20) begin
					@(negedge clock);
					n++;
				end
				chk({7'h0, bval}, {7'h0, acc});
				if (acc) chk(bdata, b);
				if (acc) chk({7'h0, rdy}, 8'h00);
				if (!acc) chk({7'h0, rdy}, 8'h01);
				if (acc && bval !== 1'b1) tally_and_finish();
			end
		join
	endtask
	initial begin
		forever #2.5 clock = ~clock;
	end
	// Main sequence; inputs move on the falling edge
	initial begin
		void'($urandom(32'h47e8));
		wait_n(20);
		rst_n = 1;
		wait_n(4);
		chk({6'h0, rdy, rdy_oe}, 8'h03);
		host.rs(0);
		wait_n(5);
		chk({6'h0, sdb_oe, sdb}, 8'h03);
		host.rs(1);
		start = 1;
		wait_n(1);
		start = 0;
		send(8'h00, 1);
		send(8'hff, 1);
		for (int i = 0; i < 8; i++) send(8'($urandom), 1);
		sel = 0;
		send(8'h5a, 0);
		sel = 1;
		sel_n = 1;
		send(8'ha5, 0);
		sel_n = 0;
		rmode = 1;
		for (int i = 0; i < 8; i++) begin
			upd = i[0];
			preq = 3'(i);
			pload = 1;
			wait_n(1);
			pload = 0;
			wait_n(4);
			chk({3'h0, pg_oe, rupd, pg}, {4'h1, i[0], 3'(i)});
		end
		rmode = 0;
		wait_n(3);
		chk({6'h0, pg_oe, rupd}, 8'h00);
		cdone = 1;
		wait_n(1);
		cdone = 0;
		wait_n(2);
		chk({4'h0, ph, rdy_oe, rdy}, 8'h0b);
		idone = 1;
		wait_n(1);
		idone = 0;
		wait_n(2);
		chk({4'h0, ph, rel, rdy_oe}, 8'h0e);
		rst_n = 0;
		mode = 0;
		wait_n(2);
		rst_n = 1;
		host.rs(0);
		wait_n(5);
		chk({6'h0, rdy_oe, sdb_oe}, 8'h00);
		host.rs(1);
		tally_and_finish();
	end
endmodule // test_ppac_port
